// >>> pkg/board_config_defines.vh
// constants for the board configuration and reset controller
// assumes a 250 MHz ref_clk; all counts are in ref_clk cycles
`ifndef BOARD_CONFIG_DEFINES_VH
`define BOARD_CONFIG_DEFINES_VH
`define CLK_MHZ 250
`define DEBOUNCE_US 2
`define DEBOUNCE_CYC (`DEBOUNCE_US * `CLK_MHZ)
`define FAST_BLINK_MS 100
`define FAST_BLINK_CYC (`FAST_BLINK_MS * 1000 * `CLK_MHZ)
`define SLOW_BLINK_MS 500
`define SLOW_BLINK_CYC (`SLOW_BLINK_MS * 1000 * `CLK_MHZ)
`define AS_WAIT_MS 200
`define AS_WAIT_CYC (`AS_WAIT_MS * 1000 * `CLK_MHZ)
`define DONE_WAIT_CYC 32'h00000100
`define USER_IMG_BASE 24'hc00000
`define FACTORY_IMG_BASE 24'he00000
`define IMG_BYTES 24'h100000
`define ADDR_W 24
`define SRC_N 3
`endif

// >>> hw/debounce_bank.v
// synchroniser and debouncer bank for the active-low trigger inputs
// assumes inputs may be asynchronous to ref_clk; outputs one-cycle press pulses
`timescale 1ns/100ps
`include "board_config_defines.vh"
module debounce_bank #(
  parameter N = 3,
  parameter [31:0] DEB_CYC = `DEBOUNCE_CYC
) (
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [N-1:0] raw_low,
  output wire [N-1:0] press_pulse
);
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : ch
      reg meta_ff; // first stage, read only by sync_ff
      reg sync_ff;
      reg stable_ff; // debounced level, high while pressed
      reg pulse_ff;
      reg [31:0] cnt_ff;
      // two-flop synchroniser then counter filter
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          stable_ff <= 1'b0;
          pulse_ff <= 1'b0;
          cnt_ff <= 32'h00000000;
        end else if (clk_en) begin
          meta_ff <= ~raw_low[g];
          sync_ff <= meta_ff;
          pulse_ff <= 1'b0;
          if (sync_ff == stable_ff) begin
            cnt_ff <= 32'h00000000;
          end else if (cnt_ff >= DEB_CYC - 32'h00000001) begin
            // level held long enough: accept it, pulse on press only
            cnt_ff <= 32'h00000000;
            stable_ff <= sync_ff;
            pulse_ff <= sync_ff;
          end else begin
            cnt_ff <= cnt_ff + 32'h00000001;
          end
        end
      end
      assign press_pulse[g] = pulse_ff;
    end
  endgenerate
endmodule

// >>> hw/board_config_reset_controller.v
// board configuration and reset controller: sequences loading of the logic device
// assumes synchronous pins except the factory and reset/config buttons and the request, which go through debounce_bank
`timescale 1ns/100ps
`include "board_config_defines.vh"
module board_config_reset_controller #(
  parameter [31:0] DEB_CYC = `DEBOUNCE_CYC,
  parameter [31:0] FAST_CYC = `FAST_BLINK_CYC,
  parameter [31:0] SLOW_CYC = `SLOW_BLINK_CYC,
  parameter [31:0] AS_CYC = `AS_WAIT_CYC
) (
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  input wire por_pulse_low,
  input wire cpu_reset_button_low,
  input wire factory_config_button_low,
  input wire reset_config_button_low,
  input wire reconfig_req_low,
  input wire config_done,
  input wire status_low,
  input wire [7:0] shared_user_line_in,
  input wire [7:0] flash_data,
  output reg device_clear_low,
  output reg config_start_low,
  output reg active_serial_mode,
  output reg passive_serial_mode,
  output reg serial_config_data_in,
  output reg dclk,
  output reg flash_ce_low,
  output reg flash_oe_low,
  output reg [23:0] flash_addr,
  output reg [7:0] shared_user_line_out,
  output reg [7:0] shared_user_line_oe,
  output reg eth_reset_low,
  output reg flash_reset_low,
  output reg card_reset_low,
  output reg expansion_reset_low,
  output reg loading_indicator,
  output reg error_indicator,
  output reg user_image_indicator,
  output reg factory_image_indicator,
  output reg done_indicator,
  output reg flash_activity_indicator
);
  // one-hot states
  localparam [6:0] S_IDLE = 7'h01, S_START = 7'h02, S_AS = 7'h04, S_PS_INIT = 7'h08,
    S_STREAM = 7'h10, S_WAITDONE = 7'h20, S_STOP = 7'h40;
  localparam [1:0] SRC_USER = 2'h1, SRC_FACT = 2'h2;

  wire [2:0] press; // 0 reset/config, 1 factory, 2 reconfig request
  reg [6:0] state_ff;
  reg [1:0] src_ff; // flash image currently being streamed
  reg [31:0] wait_ff; // timeout for active serial and done wait
  reg [23:0] offs_ff; // byte offset inside the image
  reg [7:0] shift_ff; // byte being serialised
  reg [2:0] bit_ff;
  reg [31:0] fast_ff;
  reg [31:0] slow_ff;
  reg fast_tgl_ff;
  reg slow_tgl_ff;
  reg por_seen_ff; // first cycle after reset starts a power-on sequence
  reg as_ok_ff; // success came from serial flash
  reg user_ok_ff;
  reg fact_ok_ff;

  debounce_bank #(.N(3), .DEB_CYC(DEB_CYC)) u_deb (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .raw_low({reconfig_req_low, factory_config_button_low, reset_config_button_low}),
    .press_pulse(press)
  );

  // image base for a flash source
  function [23:0] img_base;
    input [1:0] src;
    begin
      img_base = (src == SRC_FACT) ? `FACTORY_IMG_BASE : `USER_IMG_BASE;
    end
  endfunction

  // blink dividers, free running; the slow one only matters after serial success
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_ff <= 32'h00000000;
      slow_ff <= 32'h00000000;
      fast_tgl_ff <= 1'b0;
      slow_tgl_ff <= 1'b0;
    end else if (clk_en) begin
      fast_ff <= (fast_ff >= FAST_CYC - 32'h00000001) ? 32'h00000000 : fast_ff + 32'h00000001;
      if (fast_ff >= FAST_CYC - 32'h00000001) begin
        fast_tgl_ff <= ~fast_tgl_ff;
      end
      slow_ff <= (slow_ff >= SLOW_CYC - 32'h00000001) ? 32'h00000000 : slow_ff + 32'h00000001;
      if (slow_ff >= SLOW_CYC - 32'h00000001) begin
        slow_tgl_ff <= ~slow_tgl_ff;
      end
    end
  end

  // pass-through pins, each registered so outputs come from flops
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      device_clear_low <= 1'b0;
      eth_reset_low <= 1'b0;
      flash_reset_low <= 1'b0;
      card_reset_low <= 1'b0;
      expansion_reset_low <= 1'b0;
      done_indicator <= 1'b0;
      flash_activity_indicator <= 1'b0;
      shared_user_line_out <= 8'h00;
      shared_user_line_oe <= 8'h00;
    end else if (clk_en) begin
      device_clear_low <= cpu_reset_button_low;
      eth_reset_low <= por_pulse_low;
      flash_reset_low <= por_pulse_low;
      card_reset_low <= por_pulse_low;
      expansion_reset_low <= por_pulse_low;
      done_indicator <= config_done;
      flash_activity_indicator <= ~flash_ce_low;
      // never drive shared lines; the logic device owns them
      shared_user_line_out <= 8'h00;
      shared_user_line_oe <= 8'h00;
    end
  end

  // configuration sequencer
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= S_IDLE;
      src_ff <= SRC_USER;
      wait_ff <= 32'h00000000;
      offs_ff <= 24'h000000;
      shift_ff <= 8'h00;
      bit_ff <= 3'h0;
      por_seen_ff <= 1'b0;
      as_ok_ff <= 1'b0;
      user_ok_ff <= 1'b0;
      fact_ok_ff <= 1'b0;
      config_start_low <= 1'b1;
      active_serial_mode <= 1'b0;
      passive_serial_mode <= 1'b0;
      serial_config_data_in <= 1'b0;
      dclk <= 1'b0;
      flash_ce_low <= 1'b1;
      flash_oe_low <= 1'b1;
      flash_addr <= 24'h000000;
      loading_indicator <= 1'b0;
      error_indicator <= 1'b0;
      user_image_indicator <= 1'b0;
      factory_image_indicator <= 1'b0;
    end else if (clk_en) begin
      por_seen_ff <= 1'b1;
      dclk <= 1'b0;
      if (!por_seen_ff || press != 3'h0) begin
        loading_indicator <= 1'b0;
        error_indicator <= 1'b0;
        user_image_indicator <= 1'b0;
        factory_image_indicator <= 1'b0;
        as_ok_ff <= 1'b0;
        user_ok_ff <= 1'b0;
        fact_ok_ff <= 1'b0;
        flash_ce_low <= 1'b1;
        flash_oe_low <= 1'b1;
        config_start_low <= 1'b0;
        wait_ff <= 32'h00000000;
        src_ff <= press[1] ? SRC_FACT : SRC_USER;
        active_serial_mode <= ~press[1];
        passive_serial_mode <= press[1];
        state_ff <= S_START;
      end else begin
        case (state_ff)
          S_IDLE: begin
            config_start_low <= 1'b1;
          end
          S_START: begin
            config_start_low <= 1'b1;
            state_ff <= passive_serial_mode ? S_PS_INIT : S_AS;
          end
          S_AS: begin
            // serial flash first in active serial
            if (config_done) begin
              as_ok_ff <= 1'b1;
              state_ff <= S_STOP;
            end else if (wait_ff >= AS_CYC - 32'h00000001) begin
              active_serial_mode <= 1'b0;
              passive_serial_mode <= 1'b1;
              config_start_low <= 1'b0;
              state_ff <= S_PS_INIT;
            end else begin
              wait_ff <= wait_ff + 32'h00000001;
            end
          end
          S_PS_INIT: begin
            // pulse start low one cycle, then open the flash image
            config_start_low <= 1'b1;
            offs_ff <= 24'h000000;
            bit_ff <= 3'h0;
            wait_ff <= 32'h00000000;
            flash_addr <= img_base(src_ff);
            flash_ce_low <= 1'b0;
            flash_oe_low <= 1'b0;
            user_image_indicator <= (src_ff == SRC_USER);
            factory_image_indicator <= (src_ff == SRC_FACT);
            state_ff <= S_STREAM;
          end
          S_STREAM: begin
            loading_indicator <= fast_tgl_ff;
            // stream bytes lsb first, one bit per two cycles
            if (!dclk) begin
              serial_config_data_in <= (bit_ff == 3'h0) ? flash_data[0] : shift_ff[bit_ff];
              if (bit_ff == 3'h0) begin
                shift_ff <= flash_data;
              end
              dclk <= 1'b1;
            end else begin
              bit_ff <= bit_ff + 3'h1;
              if (bit_ff == 3'h7) begin
                offs_ff <= offs_ff + 24'h000001;
                flash_addr <= img_base(src_ff) + offs_ff + 24'h000001;
              end
            end
            if (!status_low || config_done || (offs_ff == `IMG_BYTES - 24'h000001 &&
                bit_ff == 3'h7 && dclk)) begin
              flash_ce_low <= 1'b1;
              flash_oe_low <= 1'b1;
              loading_indicator <= 1'b0;
              state_ff <= S_WAITDONE;
            end
          end
          S_WAITDONE: begin
            if (config_done) begin
              user_ok_ff <= (src_ff == SRC_USER);
              fact_ok_ff <= (src_ff == SRC_FACT);
              state_ff <= S_STOP;
            end else if (wait_ff >= `DONE_WAIT_CYC - 32'h00000001) begin
              // timeout: user image falls back to factory, factory image sets error
              user_image_indicator <= 1'b0;
              factory_image_indicator <= 1'b0;
              if (src_ff == SRC_USER) begin
                src_ff <= SRC_FACT;
                config_start_low <= 1'b0;
                state_ff <= S_PS_INIT;
              end else begin
                error_indicator <= 1'b1;
                passive_serial_mode <= 1'b0;
                state_ff <= S_IDLE;
              end
            end else begin
              wait_ff <= wait_ff + 32'h00000001;
            end
          end
          S_STOP: begin
            // slow blink after serial success, else steady
            user_image_indicator <= as_ok_ff ? slow_tgl_ff : user_ok_ff;
            factory_image_indicator <= fact_ok_ff;
          end
          default: begin
            state_ff <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// >>> testbench/pld_flash_model.sv
// partner: the logic device being configured plus the parallel flash
// assumes one ref_clk domain; the ok inputs pick which sources succeed
`timescale 1ns/100ps
module pld_flash_model (
  input wire ref_clk,
  input wire rst_b,
  input wire as_ok,
  input wire user_ok,
  input wire fac_ok,
  input wire config_start_low,
  input wire active_serial_mode,
  input wire passive_serial_mode,
  input wire serial_config_data_in,
  input wire dclk,
  input wire flash_ce_low,
  input wire flash_oe_low,
  input wire [23:0] flash_addr,
  input wire device_clear_low,
  output reg config_done,
  output reg status_low,
  output wire [7:0] flash_data,
  output reg data_bad,
  output reg [7:0] cpu_pc
);
  reg [31:0] cnt_ff; // serial-mode cycles or bits taken
  reg [7:0] idle_ff; // bus noise while the flash is not read
  wire [7:0] img_byte; // pattern stored at each flash address
  assign img_byte = flash_addr[7:0] ^ 8'h5a;
  // data valid in the same cycle as the address; a released bus flips so it never looks valid
  assign flash_data = (!flash_ce_low && !flash_oe_low) ? img_byte : idle_ff;
  // a low clear sends the loaded processor back to its reset address
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      cpu_pc <= 8'h00;
    else if (!device_clear_low)
      cpu_pc <= 8'h00;
    else
      cpu_pc <= cpu_pc + 8'h01;
  end
  // device and flash in one process; short images keep runs brief
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      config_done <= 1'b0;
      status_low <= 1'b1;
      idle_ff <= 8'h00;
      data_bad <= 1'b0;
      cnt_ff <= 32'h0;
    end else begin
      idle_ff <= ~idle_ff;
      // each start pulse restarts the device
      if (!config_start_low) begin
        config_done <= 1'b0;
        status_low <= 1'b1;
        cnt_ff <= 32'h0;
      end else if (active_serial_mode && !passive_serial_mode && as_ok) begin
        cnt_ff <= cnt_ff + 32'h1;
        if (cnt_ff == 32'ha)
          config_done <= 1'b1;
      end else if (flash_ce_low) begin
        cnt_ff <= 32'h0;
        status_low <= 1'b1;
      end else if (dclk) begin
        cnt_ff <= cnt_ff + 32'h1;
        // bits of the addressed byte arrive lsb first, one per clock pulse
        if (serial_config_data_in != img_byte[cnt_ff[2:0]])
          data_bad <= 1'b1;
        // address bit 21 tells the factory image from the user one
        if (cnt_ff == 32'h28) begin
          if (flash_addr[21] ? fac_ok : user_ok)
            config_done <= 1'b1;
          else
            status_low <= 1'b0;
        end
      end
    end
  end
endmodule

// >>> testbench/board_config_sva.sv
// assertions on the controller's pins
// assumes nothing is judged while clk_en freezes the controller
`timescale 1ns/100ps
module board_config_sva (
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  input wire cpu_reset_button_low,
  input wire por_pulse_low,
  input wire config_done,
  input wire device_clear_low,
  input wire config_start_low,
  input wire active_serial_mode,
  input wire passive_serial_mode,
  input wire flash_ce_low,
  input wire [23:0] flash_addr,
  input wire [7:0] shared_user_line_oe,
  input wire eth_reset_low,
  input wire card_reset_low,
  input wire loading_indicator,
  input wire error_indicator,
  input wire factory_image_indicator,
  input wire done_indicator,
  input wire flash_activity_indicator
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b || !clk_en);
  a_clear_follows_button: assert property (
    $fell(cpu_reset_button_low) |=> !device_clear_low) else $error("clear not low");
  a_reset_fan_out: assert property (
    !por_pulse_low |=> !eth_reset_low && !card_reset_low) else $error("reset not passed");
  a_done_led: assert property (
    config_done |=> done_indicator) else $error("done lamp off");
  a_flash_led: assert property (
    !flash_ce_low |=> flash_activity_indicator) else $error("flash lamp off");
  a_start_one_cycle: assert property (
    !config_start_low |=> config_start_low) else $error("start pulse too long");
  a_blink_in_stream: assert property (
    loading_indicator |-> passive_serial_mode) else $error("loading outside stream");
  a_modes_apart: assert property (
    !(active_serial_mode && passive_serial_mode)) else $error("both modes set");
  a_image_base: assert property (
    $fell(flash_ce_low) |-> flash_addr == 24'hc00000 || flash_addr == 24'he00000)
    else $error("bad image base");
  a_error_cleared: assert property (
    !config_start_low |-> ##2 !error_indicator) else $error("error kept over start");
  a_lines_idle: assert property (
    shared_user_line_oe == 8'h00) else $error("shared line driven");
  c_serial_ok: cover property (config_done && active_serial_mode);
  c_factory_on: cover property ($rose(factory_image_indicator));
  c_error_on: cover property ($rose(error_indicator));
endmodule
bind board_config_reset_controller board_config_sva u_sva (.ref_clk, .rst_b, .clk_en,
  .cpu_reset_button_low, .por_pulse_low, .config_done, .device_clear_low,
  .config_start_low, .active_serial_mode, .passive_serial_mode, .flash_ce_low,
  .flash_addr, .shared_user_line_oe, .eth_reset_low, .card_reset_low,
  .loading_indicator, .error_indicator, .factory_image_indicator, .done_indicator,
  .flash_activity_indicator);

// >>> testbench/tb_top.sv
// self-checking bench for the configuration and reset controller
// assumes the partner model answers with short images
`timescale 1ns/100ps
module tb_top;
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg por_pulse_low = 1'b1;
  reg [3:0] btn_low = 4'hf; // cpu, factory, reset/config, request
  reg as_ok = 1'b1;
  reg user_ok = 1'b0;
  reg fac_ok = 1'b0;
  reg clk_en = 1'b1;
  wire flash_oe_low, serial_config_data_in, data_bad;
  wire [7:0] cpu_pc, shared_user_line_out, shared_user_line_oe;
  wire config_done, status_low, device_clear_low, config_start_low, dclk;
  wire active_serial_mode, passive_serial_mode, flash_ce_low;
  wire eth_reset_low, flash_reset_low, card_reset_low, expansion_reset_low;
  wire loading_indicator, error_indicator, user_image_indicator;
  wire factory_image_indicator, done_indicator, flash_activity_indicator;
  wire [7:0] flash_data;
  wire [23:0] flash_addr;
  int bad_count = 0;
  int n_compared = 0;
  int n;
  always #2 ref_clk = ~ref_clk;
  board_config_reset_controller #(.DEB_CYC(32'h4), .FAST_CYC(32'h8), .SLOW_CYC(32'h10),
    .AS_CYC(32'h32)) u_dut (.ref_clk, .rst_b, .clk_en, .por_pulse_low,
    .cpu_reset_button_low(btn_low[0]), .factory_config_button_low(btn_low[1]),
    .reset_config_button_low(btn_low[2]), .reconfig_req_low(btn_low[3]), .config_done,
    .status_low, .shared_user_line_in(8'h00), .flash_data, .device_clear_low,
    .config_start_low, .active_serial_mode, .passive_serial_mode,
    .serial_config_data_in, .dclk, .flash_ce_low, .flash_oe_low, .flash_addr,
    .shared_user_line_out, .shared_user_line_oe, .eth_reset_low, .flash_reset_low,
    .card_reset_low, .expansion_reset_low, .loading_indicator, .error_indicator,
    .user_image_indicator, .factory_image_indicator, .done_indicator,
    .flash_activity_indicator);
  pld_flash_model u_far (.ref_clk, .rst_b, .as_ok, .user_ok, .fac_ok, .config_start_low,
    .active_serial_mode, .passive_serial_mode, .serial_config_data_in, .dclk,
    .flash_ce_low, .flash_oe_low, .flash_addr, .device_clear_low, .config_done,
    .status_low, .flash_data, .data_bad, .cpu_pc);
  task give_verdict;
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_addr(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // condition codes for waits and blink counting
  function automatic bit cond(input int w);
    case (w)
      0: cond = config_done === 1'b1;
      1: cond = flash_ce_low === 1'b0;
      2: cond = error_indicator === 1'b1;
      3: cond = loading_indicator === 1'b1;
      default: cond = user_image_indicator === 1'b1;
    endcase
  endfunction
  // bounded wait; running out ends the run as a failure
  task wait_on(input int w, input int lim);
    for (int i = 0; i < lim && !cond(w); i++)
      @(posedge ref_clk);
    if (!cond(w)) begin
      bad_count++;
      give_verdict;
    end
  endtask
  task toggles(input int w);
    bit p;
    n = 0;
    p = cond(w);
    repeat (40) begin
      @(posedge ref_clk);
      if (cond(w) != p)
        n++;
      p = cond(w);
    end
  endtask
  // held long enough to pass the debouncer
  task press(input int b);
    btn_low[b] <= 1'b0;
    repeat (10) @(posedge ref_clk);
    btn_low[b] <= 1'b1;
    @(posedge ref_clk);
  endtask
  task t_power_on;
    wait_on(0, 100);
    repeat (3) @(posedge ref_clk);
    chk_bit(done_indicator, 1'b1);
    chk_bit(passive_serial_mode, 1'b0);
    toggles(4);
    chk_bit(n > 1, 1'b1);
  endtask
  task t_user;
    as_ok <= 1'b0;
    user_ok <= 1'b1;
    press(2);
    wait_on(1, 200);
    @(posedge ref_clk);
    chk_addr(flash_addr, 24'hc00000);
    chk_bit(user_image_indicator, 1'b1);
    chk_bit(flash_activity_indicator, 1'b1);
    toggles(3);
    chk_bit(n > 1, 1'b1);
    wait_on(0, 400);
    repeat (3) @(posedge ref_clk);
    chk_bit(user_image_indicator, 1'b1);
    chk_bit(error_indicator, 1'b0);
    chk_bit(data_bad, 1'b0);
  endtask
  task t_retry;
    user_ok <= 1'b0;
    fac_ok <= 1'b1;
    press(3);
    wait_on(0, 1500);
    repeat (3) @(posedge ref_clk);
    chk_bit(factory_image_indicator, 1'b1);
    chk_bit(data_bad, 1'b0);
  endtask
  task t_factory;
    as_ok <= 1'b1;
    press(1);
    wait_on(1, 60);
    chk_bit(active_serial_mode, 1'b0);
    chk_addr(flash_addr, 24'he00000);
    wait_on(0, 400);
    repeat (3) @(posedge ref_clk);
    chk_bit(factory_image_indicator, 1'b1);
    chk_bit(user_image_indicator, 1'b0);
  endtask
  task t_fail;
    as_ok <= 1'b0;
    fac_ok <= 1'b0;
    press(2);
    wait_on(2, 2000);
    chk_bit(done_indicator, 1'b0);
    fac_ok <= 1'b1;
    press(1);
    chk_bit(error_indicator, 1'b0);
  endtask
  task t_resets;
    wait_on(0, 400);
    // frozen: a reset pulse must not reach the pins until clk_en returns
    clk_en <= 1'b0;
    @(posedge ref_clk);
    por_pulse_low <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_bit(eth_reset_low, 1'b1);
    por_pulse_low <= 1'b1;
    @(posedge ref_clk);
    clk_en <= 1'b1;
    @(posedge ref_clk);
    por_pulse_low <= 1'b0;
    btn_low[0] <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_bit(flash_reset_low | expansion_reset_low, 1'b0);
    chk_bit(device_clear_low, 1'b0);
    chk_addr({16'h0000, cpu_pc}, 24'h000000);
    por_pulse_low <= 1'b1;
    btn_low[0] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_bit(flash_reset_low & eth_reset_low, 1'b1);
    chk_bit(device_clear_low, 1'b1);
    chk_bit(cpu_pc == 8'h00, 1'b0);
    chk_addr({shared_user_line_out, shared_user_line_oe, 8'h00}, 24'h000000);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_power_on;
    t_user;
    t_retry;
    t_factory;
    t_fail;
    t_resets;
    give_verdict;
  end
endmodule
